// ### tmf_pkg.sv
// Package: constants and encodings of the test-mode forcing block
package tmf_pkg;

    // ****************************************************************
    // Sizes and timing
    // ****************************************************************
    localparam int unsigned TMF_N_IN = 8;
    localparam int unsigned TMF_N_OUT = 8;
    localparam int unsigned TMF_TRIG_W = 5;
    localparam int unsigned TMF_SYS_CLK_HZ = 25000000;
    localparam int unsigned TMF_FLASH_HALF_MS = 500;
    localparam int unsigned TMF_FLASH_HALF_CYC = TMF_SYS_CLK_HZ / 1000 * TMF_FLASH_HALF_MS;

    // ****************************************************************
    // Register map (byte addresses, word aligned)
    // ****************************************************************
    localparam logic [7:0] TMF_ADDR_CTRL = 8'h00;
    localparam logic [7:0] TMF_ADDR_IN_FORCE = 8'h04;
    localparam logic [7:0] TMF_ADDR_OUT_FORCE = 8'h08;
    localparam logic [7:0] TMF_ADDR_STATUS = 8'h0C;
    localparam logic [7:0] TMF_ADDR_IN_STATE = 8'h10;
    localparam logic [7:0] TMF_ADDR_OUT_STATE = 8'h14;
    localparam int unsigned TMF_CTRL_EN_BIT = 0;
    localparam int unsigned TMF_CTRL_TRIG_LSB = 8;
    localparam logic [31:0] TMF_UNMAPPED_VAL = 32'h0000_0000;
    localparam logic [TMF_TRIG_W-1:0] TMF_TRIG_CONST_ON = 5'h1_F;

    // ****************************************************************
    // Override and state encodings
    // ****************************************************************
    typedef enum logic [1:0] {
        TMF_IN_LIVE = 2'b00,
        TMF_IN_OPEN = 2'b01,
        TMF_IN_CLOSED = 2'b10,
        TMF_IN_RSVD = 2'b11
    } tmf_in_force_e;

    typedef enum logic [1:0] {
        TMF_OUT_LIVE = 2'b00,
        TMF_OUT_OPEN = 2'b01,
        TMF_OUT_CLOSE = 2'b10,
        TMF_OUT_FREEZE = 2'b11
    } tmf_out_force_e;

    typedef enum logic [1:0] {
        TMF_ST_IDLE = 2'b00,
        TMF_ST_ARMED = 2'b01,
        TMF_ST_TEST = 2'b10
    } tmf_state_e;

    localparam logic [2*TMF_N_IN-1:0] TMF_IN_FORCE_RST = 16'h0000;
    localparam logic [2*TMF_N_OUT-1:0] TMF_OUT_FORCE_RST = 16'h0000;

endpackage : tmf_pkg

// ### tmf_cfg_if.sv
// Interface: settings carried from the register slave to the control core
`timescale 1ns/1ns
`default_nettype none
interface tmf_cfg_if;
    import tmf_pkg::*;
    logic test_enable;
    logic [TMF_TRIG_W-1:0] trig_sel;
    logic [2*TMF_N_IN-1:0] in_force;
    logic [2*TMF_N_OUT-1:0] out_force;
    logic test_active;
    logic [TMF_N_IN-1:0] in_state;
    logic [TMF_N_OUT-1:0] out_state;

    modport regs (output test_enable, trig_sel, in_force, out_force,
        input test_active, in_state, out_state);
    modport core (input test_enable, trig_sel, in_force, out_force,
        output test_active, in_state, out_state);
endinterface : tmf_cfg_if
`default_nettype wire

// ### tmf_regs.sv
// Avalon-MM register slave holding test settings and showing live state
`timescale 1ns/1ns
`default_nettype none
module tmf_regs (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    tmf_cfg_if.regs cfg
);
    import tmf_pkg::*;

    // ****************************************************************
    // Settings storage
    // ****************************************************************
    logic test_enable, next_test_enable;
    logic [TMF_TRIG_W-1:0] trig_sel, next_trig_sel;
    logic [2*TMF_N_IN-1:0] in_force, next_in_force;
    logic [2*TMF_N_OUT-1:0] out_force, next_out_force;
    logic stall, next_stall;
    logic [31:0] rdata, next_rdata;

    assign cfg.test_enable = test_enable;
    assign cfg.trig_sel = trig_sel;
    assign cfg.in_force = in_force;
    assign cfg.out_force = out_force;
    assign avs_readdata = rdata;
    // Waitrequest low only in the answer cycle: one wait state per access
    assign avs_waitrequest = stall;

    // Decode; writes take effect on the edge that ends the wait
    always_comb begin
        next_test_enable = test_enable;
        next_trig_sel = trig_sel;
        next_in_force = in_force;
        next_out_force = out_force;
        next_rdata = rdata;
        next_stall = ~((avs_read | avs_write) & stall);
        if (avs_write && stall) begin
            unique case (avs_address)
                TMF_ADDR_CTRL: begin
                    if (avs_byteenable[0]) begin
                        next_test_enable = avs_writedata[TMF_CTRL_EN_BIT];
                    end
                    if (avs_byteenable[1]) begin
                        next_trig_sel = avs_writedata[TMF_CTRL_TRIG_LSB +: TMF_TRIG_W];
                    end
                end
                TMF_ADDR_IN_FORCE: begin
                    if (avs_byteenable[0]) next_in_force[7:0] = avs_writedata[7:0];
                    if (avs_byteenable[1]) next_in_force[15:8] = avs_writedata[15:8];
                end
                TMF_ADDR_OUT_FORCE: begin
                    if (avs_byteenable[0]) next_out_force[7:0] = avs_writedata[7:0];
                    if (avs_byteenable[1]) next_out_force[15:8] = avs_writedata[15:8];
                end
                default: ;
            endcase
        end
        if (avs_read && stall) begin
            unique case (avs_address)
                TMF_ADDR_CTRL: next_rdata = {19'h0_0000, trig_sel, 7'h00, test_enable};
                TMF_ADDR_IN_FORCE: next_rdata = {16'h0000, in_force};
                TMF_ADDR_OUT_FORCE: next_rdata = {16'h0000, out_force};
                TMF_ADDR_STATUS: next_rdata = {31'h0000_0000, cfg.test_active};
                TMF_ADDR_IN_STATE: next_rdata = {24'h00_0000, cfg.in_state};
                TMF_ADDR_OUT_STATE: next_rdata = {24'h00_0000, cfg.out_state};
                default: next_rdata = TMF_UNMAPPED_VAL;
            endcase
        end
    end

    // Register stage
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            test_enable <= 1'b0;
            trig_sel <= '0;
            in_force <= TMF_IN_FORCE_RST;
            out_force <= TMF_OUT_FORCE_RST;
            stall <= 1'b1;
            rdata <= 32'h0000_0000;
        end else begin
            test_enable <= next_test_enable;
            trig_sel <= next_trig_sel;
            in_force <= next_in_force;
            out_force <= next_out_force;
            stall <= next_stall;
            rdata <= next_rdata;
        end
    end
endmodule : tmf_regs
`default_nettype wire

// ### tmf_contacts.sv
// Per-contact input and output forcing with freeze capture
`timescale 1ns/1ns
`default_nettype none
module tmf_contacts (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic test_active,
    input wire logic test_start,
    input wire logic [tmf_pkg::TMF_N_IN-1:0] in_sensed,
    input wire logic [tmf_pkg::TMF_N_OUT-1:0] out_operand,
    input wire logic [2*tmf_pkg::TMF_N_IN-1:0] in_force,
    input wire logic [2*tmf_pkg::TMF_N_OUT-1:0] out_force,
    output logic [tmf_pkg::TMF_N_IN-1:0] in_report,
    output logic [tmf_pkg::TMF_N_OUT-1:0] out_drive
);
    import tmf_pkg::*;

    // ****************************************************************
    // One lane per contact
    // ****************************************************************
    logic [TMF_N_OUT-1:0] frozen, next_frozen;
    logic [TMF_N_OUT-1:0] last_drive, next_last_drive;

    genvar gi;
    generate
        for (gi = 0; gi < TMF_N_IN; gi++) begin : g_in
            // Reserved code acts as live so a bad setting never blinds an input
            always_comb begin
                in_report[gi] = in_sensed[gi]; // see R8 R11
                if (test_active) begin
                    unique case (tmf_in_force_e'(in_force[2*gi +: 2]))
                        TMF_IN_OPEN: in_report[gi] = 1'b0; // see R9
                        TMF_IN_CLOSED: in_report[gi] = 1'b1; // see R10
                        default: in_report[gi] = in_sensed[gi]; // see R8
                    endcase
                end
            end
        end
        for (gi = 0; gi < TMF_N_OUT; gi++) begin : g_out
            always_comb begin
                next_frozen[gi] = test_start ? last_drive[gi] : frozen[gi];
                out_drive[gi] = out_operand[gi]; // see R5
                if (test_active) begin
                    unique case (tmf_out_force_e'(out_force[2*gi +: 2])) // see R6 R7
                        TMF_OUT_OPEN: out_drive[gi] = 1'b0; // see R15
                        TMF_OUT_CLOSE: out_drive[gi] = 1'b1; // see R14
                        TMF_OUT_FREEZE: out_drive[gi] = frozen[gi]; // see R13
                        TMF_OUT_LIVE: out_drive[gi] = out_operand[gi];
                    endcase
                end
            end
        end
    endgenerate

    assign next_last_drive = out_drive;

    // Remember the pre-test position; frozen copy is taken on the entry cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            frozen <= '0;
            last_drive <= '0;
        end else begin
            frozen <= next_frozen; // see R13
            last_drive <= next_last_drive;
        end
    end
endmodule : tmf_contacts
`default_nettype wire

// ### tmf_top.sv
// Top: test-mode entry, indicator flashing, contact forcing and register access
//
// What this block does
// R1: Test mode only while enable is set and selected trigger is one.
// R2: With trigger fixed On, test starts when enable goes from off to on.
// R3: With an operand trigger, test starts when it becomes one while enabled.
// R4: Indicator lamp flashes for as long as test mode lasts.
// R5: Protection, logic and communication signals pass unchanged during test.
// R6: Each output may be forced open, closed, frozen or left operational.
// R7: Every input and every output has its own override selection.
// R8: Input with override disabled keeps reporting its terminal state.
// R9: Input with override Open reports zero throughout test mode.
// R10: Input with override Closed reports one throughout test mode.
// R11: All inputs follow terminals once every input override is disabled.
// R12: Software should leave the trigger input's override disabled.
// R13: Frozen output keeps its pre-test position until test mode ends.
// R14: Energized output stays closed for the whole test.
// R15: De-energized output stays open for the whole test.
// R16: Test ends, lamp stops, overrides release when enable or trigger drops.
`timescale 1ns/1ns
`default_nettype none
module tmf_top (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [tmf_pkg::TMF_N_IN-1:0] contact_in_pin,
    input wire logic [tmf_pkg::TMF_N_OUT-1:0] out_operand,
    input wire logic [tmf_pkg::TMF_N_IN-1:0] logic_in,
    input wire logic [tmf_pkg::TMF_N_OUT-1:0] logic_out,
    output logic [tmf_pkg::TMF_N_IN-1:0] contact_in_state,
    output logic [tmf_pkg::TMF_N_OUT-1:0] contact_out,
    output logic [tmf_pkg::TMF_N_IN-1:0] logic_in_pass,
    output logic [tmf_pkg::TMF_N_OUT-1:0] logic_out_pass,
    output logic test_led,
    output logic test_mode
);
    import tmf_pkg::*;

    // ****************************************************************
    // Settings and register slave
    // ****************************************************************
    tmf_cfg_if cfg ();

    tmf_regs u_regs (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .cfg(cfg)
    );

    // ****************************************************************
    // Pin synchronisers: three stages, change taken when last two agree
    // ****************************************************************
    logic [TMF_N_IN-1:0] pin_s1, pin_s2, pin_s3, pin_clean;
    logic [TMF_N_IN-1:0] next_pin_clean;

    // Stage one is read only by stage two
    always_comb begin
        next_pin_clean = pin_clean;
        for (int i = 0; i < TMF_N_IN; i++) begin
            if (pin_s2[i] == pin_s3[i]) begin
                next_pin_clean[i] = pin_s3[i];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
            pin_clean <= '0;
        end else begin
            pin_s1 <= contact_in_pin;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_clean <= next_pin_clean;
        end
    end

    // ****************************************************************
    // Trigger source selection
    // ****************************************************************
    // Codes 0..N_IN-1 pick a reported contact input, next N_OUT pick a logic output,
    // all-ones is constant On; others evaluate zero so test never starts.
    logic trig_val;
    logic [TMF_N_IN-1:0] in_report;

    always_comb begin
        trig_val = 1'b0;
        if (cfg.trig_sel == TMF_TRIG_CONST_ON) begin
            trig_val = 1'b1;
        end else if (cfg.trig_sel < TMF_TRIG_W'(TMF_N_IN)) begin
            trig_val = in_report[cfg.trig_sel[2:0]]; // see R12
        end else if (cfg.trig_sel < TMF_TRIG_W'(TMF_N_IN + TMF_N_OUT)) begin
            trig_val = logic_out[3'(cfg.trig_sel - TMF_TRIG_W'(TMF_N_IN))];
        end
    end

    // ****************************************************************
    // Test-mode state machine
    // ****************************************************************
    // ARMED waits for a rising condition; a trigger already high when the
    // enable rises is taken in IDLE and starts test mode at once.
    tmf_state_e state, next_state;
    logic test_start;
    logic en_q, next_en_q;
    logic trig_q, next_trig_q;

    always_comb begin
        next_state = state;
        next_en_q = cfg.test_enable;
        next_trig_q = trig_val;
        test_start = 1'b0;
        unique case (state)
            TMF_ST_IDLE: begin
                if (cfg.test_enable) begin
                    next_state = TMF_ST_ARMED;
                end
                // Enable rising with trigger already one starts at once
                if (cfg.test_enable && !en_q && trig_val) begin // see R2 R3
                    next_state = TMF_ST_TEST;
                    test_start = 1'b1;
                end
            end
            TMF_ST_ARMED: begin
                if (!cfg.test_enable) begin
                    next_state = TMF_ST_IDLE;
                end else if (trig_val && !trig_q) begin // see R3
                    next_state = TMF_ST_TEST;
                    test_start = 1'b1;
                end
            end
            TMF_ST_TEST: begin
                if (!cfg.test_enable || !trig_val) begin // see R16
                    next_state = cfg.test_enable ? TMF_ST_ARMED : TMF_ST_IDLE;
                end
            end
            default: next_state = TMF_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state <= TMF_ST_IDLE;
            en_q <= 1'b0;
            trig_q <= 1'b0;
        end else begin
            state <= next_state;
            en_q <= next_en_q;
            trig_q <= next_trig_q;
        end
    end

    logic test_active;
    assign test_active = (state == TMF_ST_TEST) && cfg.test_enable && trig_val; // see R1 R16

    // ****************************************************************
    // Indicator flasher
    // ****************************************************************
    logic [23:0] flash_cnt, next_flash_cnt;
    logic led, next_led;

    // Lamp starts lit on entry so the operator sees test mode at once
    always_comb begin
        next_flash_cnt = '0;
        next_led = 1'b0;
        if (test_active) begin
            next_led = led;
            next_flash_cnt = flash_cnt + 24'h00_0001;
            if (!led && flash_cnt == 24'h00_0000) begin
                next_led = 1'b1; // see R4
            end else if (flash_cnt == 24'(TMF_FLASH_HALF_CYC)) begin
                next_flash_cnt = 24'h00_0001;
                next_led = ~led; // see R4
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            flash_cnt <= '0;
            led <= 1'b0;
        end else begin
            flash_cnt <= next_flash_cnt;
            led <= next_led;
        end
    end

    // ****************************************************************
    // Contact forcing
    // ****************************************************************
    logic [TMF_N_OUT-1:0] out_drive;

    tmf_contacts u_contacts (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .test_active(test_active),
        .test_start(test_start),
        .in_sensed(pin_clean),
        .out_operand(out_operand),
        .in_force(cfg.in_force),
        .out_force(cfg.out_force),
        .in_report(in_report),
        .out_drive(out_drive)
    );

    assign cfg.test_active = test_active;
    assign cfg.in_state = in_report;
    assign cfg.out_state = out_drive;

    // ****************************************************************
    // Output registers
    // ****************************************************************
    // Communication and logic paths are never touched by test mode
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            contact_in_state <= '0;
            contact_out <= '0;
            logic_in_pass <= '0;
            logic_out_pass <= '0;
            test_led <= 1'b0;
            test_mode <= 1'b0;
        end else begin
            contact_in_state <= in_report;
            contact_out <= out_drive;
            logic_in_pass <= logic_in; // see R5
            logic_out_pass <= logic_out; // see R5
            test_led <= next_led;
            test_mode <= test_active;
        end
    end
endmodule : tmf_top
`default_nettype wire

// ### tmf_top_properties.sv
// Checker: port-level relations of the test-mode block
`timescale 1ns/1ns
`default_nettype none
module tmf_top_properties (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [tmf_pkg::TMF_N_OUT-1:0] out_operand,
    input wire logic [tmf_pkg::TMF_N_IN-1:0] logic_in,
    input wire logic [tmf_pkg::TMF_N_OUT-1:0] logic_out,
    input wire logic [tmf_pkg::TMF_N_OUT-1:0] contact_out,
    input wire logic [tmf_pkg::TMF_N_IN-1:0] logic_in_pass,
    input wire logic [tmf_pkg::TMF_N_OUT-1:0] logic_out_pass,
    input wire logic test_led,
    input wire logic test_mode
);
    import tmf_pkg::*;
    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    // Exactly one wait state and one answer cycle
    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer after one wait state");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest stayed low");
    a_wait_idle: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
        else $error("answer without a request");
    a_unmapped_zero: assert property (!avs_waitrequest && avs_read
        && avs_address > TMF_ADDR_OUT_STATE |-> avs_readdata == TMF_UNMAPPED_VAL)
        else $error("unmapped read not zero");
    // Skip the first edge out of reset, which shows reset contents
    a_pass_in: assert property ($past(rst_b) |-> logic_in_pass == $past(logic_in))
        else $error("logic input copy wrong");
    a_pass_out: assert property ($past(rst_b) |-> logic_out_pass == $past(logic_out))
        else $error("logic output copy wrong");
    a_led_entry: assert property ($rose(test_mode) |-> test_led)
        else $error("lamp dark on test entry");
    a_led_exit: assert property (!test_mode |-> !test_led)
        else $error("lamp lit outside test mode");
    a_out_live: assert property ($past(rst_b) && !test_mode |-> contact_out == $past(out_operand))
        else $error("output ignores operand outside test");

    // Main scenarios reached
    c_entry: cover property ($rose(test_mode));
    c_exit: cover property ($fell(test_mode));
    c_read: cover property (!avs_waitrequest && avs_read);
endmodule : tmf_top_properties

bind tmf_top tmf_top_properties u_props (.sys_clk(sys_clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .out_operand(out_operand), .logic_in(logic_in), .logic_out(logic_out),
    .contact_out(contact_out), .logic_in_pass(logic_in_pass),
    .logic_out_pass(logic_out_pass), .test_led(test_led), .test_mode(test_mode));
`default_nettype wire

// ### tmf_field_model.sv
// Model of the field wiring that switches the relay contact inputs
`timescale 1ns/1ns
`default_nettype none
module tmf_field_model (
    input wire logic sys_clk,
    input wire logic [tmf_pkg::TMF_N_IN-1:0] pin_cmd,
    output logic [tmf_pkg::TMF_N_IN-1:0] contact_in_pin
);
    // Switches settle one edge after the command; never floating
    always_ff @(posedge sys_clk) begin
        contact_in_pin <= pin_cmd;
    end
endmodule : tmf_field_model
`default_nettype wire

// ### tmf_top_tb.sv
// Testbench: test-mode entry, exit and contact forcing
`timescale 1ns/1ns
`default_nettype none
module tmf_top_tb;
    import tmf_pkg::*;
    logic sys_clk, rst_b, avs_read, avs_write, avs_waitrequest, test_led, test_mode;
    logic [7:0] avs_address, pin_cmd, contact_in_pin, out_operand, logic_in, logic_out;
    logic [7:0] contact_in_state, contact_out, logic_in_pass, logic_out_pass, p, o, z, li, lo;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [15:0] fin, fout;
    logic [7:0] amap [5] = '{TMF_ADDR_CTRL, TMF_ADDR_IN_FORCE, TMF_ADDR_OUT_FORCE,
        TMF_ADDR_STATUS, 8'h20};
    int failures = 0, tests_run = 0;

    tmf_top u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .contact_in_pin(contact_in_pin),
        .out_operand(out_operand), .logic_in(logic_in), .logic_out(logic_out),
        .contact_in_state(contact_in_state), .contact_out(contact_out),
        .logic_in_pass(logic_in_pass), .logic_out_pass(logic_out_pass),
        .test_led(test_led), .test_mode(test_mode));
    tmf_field_model u_field (.sys_clk(sys_clk), .pin_cmd(pin_cmd),
        .contact_in_pin(contact_in_pin));

    // ****************************************************************
    // Clock, watchdog and helpers
    // ****************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // Sequence needs under a thousand cycles
    initial begin
        #(40 * 20000);
        failures++;
        results();
    end

    task automatic results();
        $display("tests_run %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    task automatic check(input string nm, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick

    // One access; an idle edge first keeps requests apart
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        {avs_write, avs_read} <= {wr, ~wr};
        avs_writedata <= d;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        {avs_write, avs_read} <= 2'b00;
    endtask : bus

    function automatic logic [7:0] exp_in(input logic [15:0] f, input logic [7:0] pv);
        logic [7:0] r;
        for (int i = 0; i < 8; i++)
            r[i] = (f[2*i+:2] == TMF_IN_OPEN) ? 1'b0 : (f[2*i+:2] == TMF_IN_CLOSED) ? 1'b1 : pv[i];
        return r;
    endfunction : exp_in

    function automatic logic [7:0] exp_out(input logic [15:0] f, input logic [7:0] op, fz);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) begin
            case (f[2*i+:2])
                TMF_OUT_OPEN: r[i] = 1'b0;
                TMF_OUT_CLOSE: r[i] = 1'b1;
                TMF_OUT_FREEZE: r[i] = fz[i];
                default: r[i] = op[i];
            endcase
        end
        return r;
    endfunction : exp_out

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        void'($urandom(95));
        rst_b = 1'b0;
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        {pin_cmd, out_operand, logic_in, logic_out} = '0;
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        // Reset contents; an unmapped write must vanish
        bus(1'b1, 8'h20, 32'hFFFF_FFFF);
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, amap[i], 32'h0000_0000);
            check("reset_read", rd, 32'h0000_0000);
        end
        // Steady operand gives frozen outputs a known value
        z = 8'($urandom);
        out_operand <= z;
        fin = {8'($urandom), 8'hE4};
        fout = {8'($urandom), 8'hE4};
        bus(1'b1, TMF_ADDR_IN_FORCE, {16'h0000, fin});
        bus(1'b1, TMF_ADDR_OUT_FORCE, {16'h0000, fout});
        check("mode_idle", test_mode, 1'b0);
        bus(1'b1, TMF_ADDR_CTRL, 32'h0000_1F01);
        tick(3);
        check("mode_on", test_mode, 1'b1);
        check("led_on", test_led, 1'b1);
        bus(1'b0, TMF_ADDR_STATUS, 32'h0000_0000);
        check("status", rd, 32'h0000_0001);
        for (int k = 0; k < 12; k++) begin
            p = 8'($urandom);
            o = 8'($urandom);
            li = 8'($urandom);
            lo = 8'($urandom) & 8'hFE;
            pin_cmd <= p;
            out_operand <= o;
            logic_in <= li;
            logic_out <= lo;
            tick(8);
            check("in_state", contact_in_state, exp_in(fin, p));
            check("out_drive", contact_out, exp_out(fout, o, z));
            check("pass", {logic_out_pass, logic_in_pass}, {lo, li});
            check("mode_hold", test_mode, 1'b1);
        end
        bus(1'b1, TMF_ADDR_IN_FORCE, 32'h0000_0000);
        tick(2);
        check("in_release", contact_in_state, p);
        bus(1'b1, TMF_ADDR_CTRL, 32'h0000_1F00);
        tick(2);
        check("mode_off", test_mode, 1'b0);
        check("led_off", test_led, 1'b0);
        check("out_release", contact_out, o);
        // Trigger from logic output bit 0
        bus(1'b1, TMF_ADDR_CTRL, 32'h0000_0801);
        tick(4);
        check("op_low", test_mode, 1'b0);
        logic_out <= 8'h01;
        tick(3);
        check("op_entry", test_mode, 1'b1);
        logic_out <= 8'h00;
        tick(2);
        check("op_exit", test_mode, 1'b0);
        // Trigger from input 3, left live; the rest forced closed
        pin_cmd <= 8'h00;
        bus(1'b1, TMF_ADDR_IN_FORCE, 32'h0000_AA2A);
        bus(1'b1, TMF_ADDR_CTRL, 32'h0000_0301);
        tick(10);
        check("pin_low", test_mode, 1'b0);
        pin_cmd <= 8'h08;
        tick(10);
        check("pin_entry", test_mode, 1'b1);
        check("pin_closed", contact_in_state, 8'hFF);
        pin_cmd <= 8'h00;
        tick(10);
        check("pin_exit", test_mode, 1'b0);
        results();
    end
endmodule : tmf_top_tb
`default_nettype wire
